// >>> rtl/exit_counter.sv
// start-up tick counter; wraps so it also paces the periodic limp-home exit checks of the reference clock
`timescale 1ns/1ps
module exit_counter #(
  parameter int TICKS = 4096
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic tick,
  output logic done
);
  localparam int W = $clog2(TICKS) + 1;
  localparam logic [W-1:0] LAST = W'(TICKS - 1);
  logic [W-1:0] cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else if (clear) begin
      cnt <= '0;
    end else if (tick) begin
      if (cnt == LAST) begin
        cnt <= '0;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end

  assign done = tick && !clear && (cnt == LAST);
endmodule

// >>> rtl/pll_ctrl_defs.svh
// offsets, field positions, reset values and counts for the pll and stop exit control block
`ifndef PLL_CTRL_DEFS_SVH
`define PLL_CTRL_DEFS_SVH

// register indices; byte address is four times the index
`define IDX_LOOP_MULT 10'h038
`define IDX_REF_DIV 10'h039
`define IDX_GEN_TEST 10'h03A
`define IDX_PLL_FLAGS 10'h03B
`define IDX_PLL_CONTROL 10'h03C
`define IDX_STOP_CFG 10'h040
`define IDX_STOP_STATUS 10'h041

// flag register bit positions
`define FLG_TOL_CHANGE 7
`define FLG_TOL_STATUS 6
`define FLG_LIMP_CHANGE 1
`define FLG_LIMP_ACTIVE 0

// reset values
`define RST_LOOP_MULT 6'h00
`define RST_REF_DIV 8'h00
`define RST_PLL_CONTROL 8'h60
`define RST_STOP_CFG 16'h0001

// start-up counts in slow tick cycles
`define EXIT_TICKS 4096

`endif

// >>> rtl/pll_ctrl_pkg.sv
// types shared by the pll and stop exit control block
package pll_ctrl_pkg;

  typedef enum logic [1:0] {ST_RUN, ST_STOP, ST_WAIT} stop_state_e;

  typedef struct packed {
    logic tolerance_change_irq_en;
    logic pll_power;
    logic auto_bw;
    logic wide_loop_select_n;
    logic rsvd;
    logic osc_keep_running_stop;
    logic limp_irq_en;
    logic limp_home_inhibit;
  } pll_control_s;

  typedef struct packed {
    logic [1:0] pad;
    logic [5:0] slow_div;
    logic [3:0] rsvd;
    logic bus_clk_from_pll;
    logic forced_monitor_en;
    logic clock_monitor_en;
    logic stop_exit_delay;
  } stop_cfg_s;

  typedef struct packed {
    logic pll_power;
    logic wide_loop;
    logic bus_clk_pll;
    logic [5:0] mult;
    logic [7:0] refdiv;
    logic [7:0] sys_ratio;
  } pll_drive_s;

endpackage

// >>> rtl/pll_limp_home_stop_exit_ctrl.sv
// pll programming registers, limp-home tracking and stop exit sequencing
`timescale 1ns/1ps
`include "pll_ctrl_defs.svh"
module pll_limp_home_stop_exit_ctrl #(
  parameter int EXIT_TICKS = `EXIT_TICKS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pll_supply,
  input wire logic vco_in_tolerance,
  input wire logic ref_clk_good,
  input wire logic vco_floor_tick,
  input wire logic stop_req,
  input wire logic wake_req,
  output pll_ctrl_pkg::pll_drive_s pll_drive,
  output logic cpu_run,
  output logic osc_run,
  output logic cm_reset,
  output logic lock_irq,
  output logic limp_irq,
  output logic limp_active
);
  import pll_ctrl_pkg::*;

  logic [5:0] loop_multiplier;
  logic [7:0] reference_divisor;
  pll_control_s pll_control;
  stop_cfg_s stop_cfg;
  logic tolerance_change_flag;
  logic limp_change_flag;
  logic tol_prev;
  logic limp_prev;
  stop_state_e state;
  stop_state_e next_state;
  logic next_limp;
  logic cm_fire;
  logic wr_en;
  logic mapped;
  logic pll_power_eff;
  logic limp_inhibit_eff;
  logic tol_irq_en_eff;
  logic limp_irq_en_eff;
  logic monitor_on;
  logic tol_status;
  logic slow_tick_clock_tick;
  logic tick;
  logic cnt_clear;
  logic exit_done;
  logic [31:0] rdata;

  function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
    return (a[11:2] == idx) && (a[1:0] == 2'b00);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait, read data captured in the setup cycle

  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign mapped = hit(paddr, `IDX_LOOP_MULT) || hit(paddr, `IDX_REF_DIV) ||
                  hit(paddr, `IDX_GEN_TEST) || hit(paddr, `IDX_PLL_FLAGS) ||
                  hit(paddr, `IDX_PLL_CONTROL) || hit(paddr, `IDX_STOP_CFG) ||
                  hit(paddr, `IDX_STOP_STATUS);
  assign pslverr = psel && penable && !mapped;

  ////////////////////////////////////////////////////////////////////////////
  // supply and limp-home overrides

  assign pll_power_eff = pll_control.pll_power && pll_supply;
  assign limp_inhibit_eff = pll_control.limp_home_inhibit || !pll_supply;
  assign tol_irq_en_eff = pll_control.tolerance_change_irq_en && pll_supply;
  assign limp_irq_en_eff = pll_control.limp_irq_en && pll_supply;
  assign monitor_on = stop_cfg.clock_monitor_en || stop_cfg.forced_monitor_en;
  // lock detector needs the reference, so it is blind in limp-home
  assign tol_status = vco_in_tolerance && pll_power_eff && !limp_active;

  always_comb begin
    pll_drive.pll_power = pll_power_eff || limp_active;
    // manual: bit low picks wide loop; auto: wide until in tolerance
    pll_drive.wide_loop = pll_control.auto_bw ? !tol_status :
                          !pll_control.wide_loop_select_n;
    pll_drive.bus_clk_pll = stop_cfg.bus_clk_from_pll || limp_active;
    pll_drive.mult = loop_multiplier;
    pll_drive.refdiv = reference_divisor;
    // widen before the add so a multiplier of 63 still gives 128
    pll_drive.sys_ratio = {({1'b0, loop_multiplier} + 7'h01), 1'b0};
  end

  ////////////////////////////////////////////////////////////////////////////
  // programming registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loop_multiplier <= `RST_LOOP_MULT;
    end else if (wr_en && hit(paddr, `IDX_LOOP_MULT) && !stop_cfg.bus_clk_from_pll) begin
      loop_multiplier <= pwdata[5:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reference_divisor <= `RST_REF_DIV;
    end else if (wr_en && hit(paddr, `IDX_REF_DIV) && !stop_cfg.bus_clk_from_pll) begin
      reference_divisor <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_control <= pll_control_s'(`RST_PLL_CONTROL);
    end else if (wr_en && hit(paddr, `IDX_PLL_CONTROL)) begin
      pll_control.tolerance_change_irq_en <= pwdata[7];
      pll_control.pll_power <= pwdata[6] || stop_cfg.bus_clk_from_pll;
      pll_control.auto_bw <= pwdata[5];
      if (!pll_control.auto_bw) begin
        pll_control.wide_loop_select_n <= pwdata[4];
      end
      pll_control.rsvd <= 1'b0;
      pll_control.osc_keep_running_stop <= pwdata[2];
      pll_control.limp_irq_en <= pwdata[1];
      pll_control.limp_home_inhibit <= pwdata[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_cfg <= stop_cfg_s'(`RST_STOP_CFG);
    end else if (wr_en && hit(paddr, `IDX_STOP_CFG)) begin
      stop_cfg.slow_div <= pwdata[13:8];
      // pll cannot take the bus while it is switched off
      stop_cfg.bus_clk_from_pll <= pwdata[3] && pll_power_eff;
      stop_cfg.forced_monitor_en <= pwdata[2];
      stop_cfg.clock_monitor_en <= pwdata[1];
      stop_cfg.stop_exit_delay <= pwdata[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // change flags; a new event beats a write-one clear in the same cycle

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tol_prev <= 1'b0;
      limp_prev <= 1'b1;
    end else begin
      tol_prev <= tol_status;
      limp_prev <= limp_active;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tolerance_change_flag <= 1'b0;
    end else if (limp_active) begin
      tolerance_change_flag <= 1'b0;
    end else if (tol_status != tol_prev) begin
      tolerance_change_flag <= 1'b1;
    end else if (wr_en && hit(paddr, `IDX_PLL_FLAGS) && pwdata[`FLG_TOL_CHANGE]) begin
      tolerance_change_flag <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limp_change_flag <= 1'b0;
    end else if (limp_active != limp_prev) begin
      limp_change_flag <= 1'b1;
    end else if (wr_en && hit(paddr, `IDX_PLL_FLAGS) && pwdata[`FLG_LIMP_CHANGE]) begin
      limp_change_flag <= 1'b0;
    end
  end

  assign lock_irq = tolerance_change_flag && tol_irq_en_eff;
  assign limp_irq = limp_change_flag && limp_irq_en_eff;

  ////////////////////////////////////////////////////////////////////////////
  // read mux

  always_comb begin
    rdata = 32'h0000_0000;
    if (hit(paddr, `IDX_LOOP_MULT)) begin
      rdata[5:0] = loop_multiplier;
    end else if (hit(paddr, `IDX_REF_DIV)) begin
      rdata[7:0] = reference_divisor;
    end else if (hit(paddr, `IDX_GEN_TEST)) begin
      rdata = 32'h0000_0000;
    end else if (hit(paddr, `IDX_PLL_FLAGS)) begin
      rdata[`FLG_TOL_CHANGE] = tolerance_change_flag;
      rdata[`FLG_TOL_STATUS] = tol_status;
      rdata[`FLG_LIMP_CHANGE] = limp_change_flag;
      rdata[`FLG_LIMP_ACTIVE] = limp_active;
    end else if (hit(paddr, `IDX_PLL_CONTROL)) begin
      rdata[7:0] = pll_control;
      rdata[7] = tol_irq_en_eff;
      rdata[6] = pll_power_eff;
      rdata[4] = pll_control.auto_bw ? tol_status : pll_control.wide_loop_select_n;
      rdata[1] = limp_irq_en_eff;
      rdata[0] = limp_inhibit_eff;
    end else if (hit(paddr, `IDX_STOP_CFG)) begin
      rdata[15:0] = stop_cfg;
    end else if (hit(paddr, `IDX_STOP_STATUS)) begin
      rdata[3:2] = state;
      rdata[1] = osc_run;
      rdata[0] = cpu_run;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // start-up tick; in limp-home the counter runs from the vco floor rate

  slow_tick_div u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .slow_div(stop_cfg.slow_div),
    .tick(slow_tick_clock_tick)
  );

  assign tick = limp_active ? vco_floor_tick : slow_tick_clock_tick;
  assign cnt_clear = !((state == ST_WAIT) || ((state == ST_RUN) && limp_active));

  exit_counter #(
    .TICKS(EXIT_TICKS)
  ) u_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .clear(cnt_clear),
    .tick(tick),
    .done(exit_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // stop sequencer and limp-home mode

  always_comb begin
    next_state = state;
    next_limp = limp_active;
    cm_fire = 1'b0;
    case (state)
      ST_RUN: begin
        if (limp_active && exit_done && ref_clk_good) begin
          next_limp = 1'b0;
        end else if (!limp_active && !ref_clk_good) begin
          if (!limp_inhibit_eff) begin
            next_limp = 1'b1;
          end else if (monitor_on) begin
            cm_fire = 1'b1;
          end
        end
        if (stop_req) begin
          if (limp_inhibit_eff && monitor_on) begin
            cm_fire = 1'b1;
          end else begin
            next_state = ST_STOP;
          end
        end
      end
      ST_STOP: begin
        if (wake_req) begin
          if (!stop_cfg.stop_exit_delay) begin
            next_state = ST_RUN;
            if (!limp_inhibit_eff && !ref_clk_good) begin
              next_limp = 1'b1;
            end
          end else begin
            next_state = ST_WAIT;
            if (!limp_inhibit_eff) begin
              next_limp = 1'b1;
            end
          end
        end
      end
      ST_WAIT: begin
        if (exit_done) begin
          next_state = ST_RUN;
          if (limp_active && ref_clk_good) begin
            next_limp = 1'b0;
          end
        end
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
    // without pll supply there is no vco to limp on
    if (!pll_supply) begin
      next_limp = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // limp-home is entered out of reset; the first check leaves it if the clock is good
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limp_active <= 1'b1;
    end else begin
      limp_active <= next_limp;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cm_reset <= 1'b0;
    end else begin
      cm_reset <= cm_fire;
    end
  end

  assign cpu_run = (state == ST_RUN);
  // pseudo-stop keeps the oscillator alive through stop
  assign osc_run = (state != ST_STOP) || pll_control.osc_keep_running_stop;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_delayed_wake;
    (state == ST_STOP) && wake_req && stop_cfg.stop_exit_delay;
  endsequence
  sequence s_fast_wake;
    (state == ST_STOP) && wake_req && !stop_cfg.stop_exit_delay;
  endsequence

  property p_mult_locked;
    wr_en && hit(paddr, `IDX_LOOP_MULT) && stop_cfg.bus_clk_from_pll |=> $stable(loop_multiplier);
  endproperty
  a_mult_locked: assert property (p_mult_locked) else $error("multiplier written under pll");
  property p_refdiv_locked;
    wr_en && hit(paddr, `IDX_REF_DIV) && stop_cfg.bus_clk_from_pll |=> $stable(reference_divisor);
  endproperty
  a_refdiv_locked: assert property (p_refdiv_locked) else $error("divisor written under pll");
  property p_test_zero;
    psel && !penable && hit(paddr, `IDX_GEN_TEST) |=> prdata == 32'h0000_0000;
  endproperty
  a_test_zero: assert property (p_test_zero) else $error("test register not zero");
  property p_lock_flag_limp;
    limp_active |=> !tolerance_change_flag;
  endproperty
  a_lock_flag_limp: assert property (p_lock_flag_limp) else $error("lock flag set in limp");
  property p_limp_flag;
    $changed(limp_active) |=> limp_change_flag;
  endproperty
  a_limp_flag: assert property (p_limp_flag) else $error("limp change not flagged");
  property p_lock_irq;
    lock_irq == (tolerance_change_flag && pll_control.tolerance_change_irq_en && pll_supply);
  endproperty
  a_lock_irq: assert property (p_lock_irq) else $error("lock irq mismatch");
  property p_power_limp;
    limp_active |-> pll_drive.pll_power && pll_drive.bus_clk_pll && !tol_status;
  endproperty
  a_power_limp: assert property (p_power_limp) else $error("limp overrides missing");
  property p_monitor_reset;
    (state == ST_RUN) && stop_req && limp_inhibit_eff && monitor_on |=> cm_reset && cpu_run;
  endproperty
  a_monitor_reset: assert property (p_monitor_reset) else $error("no monitor reset");
  property p_delay_hold;
    s_delayed_wake |=> !cpu_run [*2];
  endproperty
  a_delay_hold: assert property (p_delay_hold) else $error("delayed exit ran early");
  property p_wait_end;
    (state == ST_WAIT) && !exit_done |=> !cpu_run;
  endproperty
  a_wait_end: assert property (p_wait_end) else $error("left wait before count");
  property p_fast_wake;
    s_fast_wake |=> cpu_run;
  endproperty
  a_fast_wake: assert property (p_fast_wake) else $error("fast exit waited");
  property p_limp_enter;
    (state == ST_RUN) && !limp_active && !ref_clk_good && !limp_inhibit_eff && pll_supply
      |=> limp_active;
  endproperty
  a_limp_enter: assert property (p_limp_enter) else $error("reference loss not limped");
endmodule

// >>> rtl/slow_tick_div.sv
// slow tick enable divider, follows the reduced-rate divider setting
`timescale 1ns/1ps
module slow_tick_div (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [5:0] slow_div,
  output logic tick
);
  logic [7:0] cnt;
  logic [7:0] ratio;

  // tick rate is the divided clock halved: 2 when bypassed, else 4 per divider step
  always_comb begin
    if (slow_div == 6'h00) begin
      ratio = 8'h02;
    end else begin
      ratio = {slow_div, 2'b00};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
    end else if (cnt >= ratio - 8'h01) begin
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end

  assign tick = (cnt >= ratio - 8'h01);
endmodule

// >>> sim/pll_limp_home_stop_exit_ctrl_tb_top.sv
// self-checking bench for the pll and stop exit control block
`timescale 1ns/1ps
`include "pll_ctrl_defs.svh"
module pll_limp_home_stop_exit_ctrl_tb_top;
  import pll_ctrl_pkg::*;
  localparam int TICKS = 8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr;
  logic pll_supply = 1'b1, vco_in_tolerance = 1'b0, ref_clk_good = 1'b1;
  logic vco_floor_tick = 1'b0, stop_req = 1'b0, wake_req = 1'b0;
  pll_drive_s pll_drive;
  logic cpu_run, osc_run, cm_reset, lock_irq, limp_irq, limp_active;
  int errors = 0;
  int checks_done = 0;
  logic [31:0] rd;
  logic er;

  always #5 pclk = ~pclk;

  pll_limp_home_stop_exit_ctrl #(.EXIT_TICKS(TICKS)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pll_supply(pll_supply), .vco_in_tolerance(vco_in_tolerance),
    .ref_clk_good(ref_clk_good), .vco_floor_tick(vco_floor_tick), .stop_req(stop_req),
    .wake_req(wake_req), .pll_drive(pll_drive), .cpu_run(cpu_run), .osc_run(osc_run),
    .cm_reset(cm_reset), .lock_irq(lock_irq), .limp_irq(limp_irq),
    .limp_active(limp_active)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  // held unchanged from setup until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask

  task automatic pulse_stop();
    @(posedge pclk);
    stop_req <= 1'b1;
    @(posedge pclk);
    stop_req <= 1'b0;
  endtask

  task automatic pulse_wake();
    @(posedge pclk);
    wake_req <= 1'b1;
    @(posedge pclk);
    wake_req <= 1'b0;
  endtask

  task automatic vco_ticks(input int n);
    repeat (n) begin
      @(posedge pclk);
      vco_floor_tick <= 1'b1;
      @(posedge pclk);
      vco_floor_tick <= 1'b0;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_map();
    chk(limp_active, 1'b1);
    rchk(`IDX_LOOP_MULT, 32'h0);
    rchk(`IDX_REF_DIV, 32'h0);
    rchk(`IDX_PLL_CONTROL, 32'h60);
    rchk(`IDX_STOP_CFG, 32'h1);
    rchk(`IDX_STOP_STATUS, 32'h3);
    apb(1'b1, `IDX_GEN_TEST, 32'hFF);
    rchk(`IDX_GEN_TEST, 32'h0);
    apb(1'b0, 10'h3F0, 32'h0);
    chk(er, 1'b1);
    chk(pready, 1'b1);
    $display("test reset_map done");
  endtask

  task automatic t_limp_exit();
    apb(1'b1, `IDX_PLL_CONTROL, 32'h62);
    vco_ticks(TICKS);
    cyc(3);
    chk(limp_active, 1'b0);
    chk(limp_irq, 1'b1);
    rchk(`IDX_PLL_FLAGS, 32'h02);
    apb(1'b1, `IDX_PLL_FLAGS, 32'h02);
    rchk(`IDX_PLL_FLAGS, 32'h00);
    chk(limp_irq, 1'b0);
    $display("test limp_exit done");
  endtask

  task automatic t_tolerance();
    apb(1'b1, `IDX_PLL_CONTROL, 32'hE0);
    vco_in_tolerance <= 1'b1;
    cyc(3);
    rchk(`IDX_PLL_FLAGS, 32'hC0);
    chk(lock_irq, 1'b1);
    chk(pll_drive.wide_loop, 1'b0);
    apb(1'b1, `IDX_PLL_FLAGS, 32'hC0);
    rchk(`IDX_PLL_FLAGS, 32'h40);
    chk(lock_irq, 1'b0);
    vco_in_tolerance <= 1'b0;
    cyc(3);
    rchk(`IDX_PLL_FLAGS, 32'h80);
    apb(1'b1, `IDX_PLL_FLAGS, 32'h80);
    apb(1'b1, `IDX_PLL_CONTROL, 32'h40);
    cyc(0);
    chk(pll_drive.wide_loop, 1'b1);
    apb(1'b1, `IDX_PLL_CONTROL, 32'h50);
    cyc(0);
    chk(pll_drive.wide_loop, 1'b0);
    $display("test tolerance done");
  endtask

  task automatic t_write_lock();
    apb(1'b1, `IDX_LOOP_MULT, 32'h05);
    apb(1'b1, `IDX_REF_DIV, 32'h03);
    cyc(0);
    chk(pll_drive.sys_ratio, 8'h0C);
    chk(pll_drive.refdiv, 8'h03);
    chk(pll_drive.mult, 6'h05);
    apb(1'b1, `IDX_STOP_CFG, 32'h09);
    cyc(0);
    chk(pll_drive.bus_clk_pll, 1'b1);
    apb(1'b1, `IDX_LOOP_MULT, 32'h2A);
    rchk(`IDX_LOOP_MULT, 32'h05);
    apb(1'b1, `IDX_REF_DIV, 32'h7F);
    rchk(`IDX_REF_DIV, 32'h03);
    apb(1'b1, `IDX_PLL_CONTROL, 32'h10);
    rchk(`IDX_PLL_CONTROL, 32'h50);
    apb(1'b1, `IDX_STOP_CFG, 32'h01);
    apb(1'b1, `IDX_LOOP_MULT, 32'h3F);
    cyc(0);
    chk(pll_drive.sys_ratio, 8'h80);
    $display("test write_lock done");
  endtask

  task automatic t_monitor_reset();
    logic seen;
    seen = 1'b0;
    apb(1'b1, `IDX_PLL_CONTROL, 32'h41);
    apb(1'b1, `IDX_STOP_CFG, 32'h03);
    pulse_stop();
    repeat (4) begin
      @(posedge pclk);
      if (cm_reset === 1'b1) seen = 1'b1;
    end
    chk(seen, 1'b1);
    chk(cpu_run, 1'b1);
    apb(1'b1, `IDX_STOP_CFG, 32'h01);
    $display("test monitor_reset done");
  endtask

  // slow tick every 2 cycles with divider 0, so the wait is 2*TICKS cycles
  task automatic t_stop_delay(input logic keep);
    int n;
    apb(1'b1, `IDX_PLL_CONTROL, {28'h0, 4'h1} | (keep ? 32'h45 : 32'h41));
    pulse_stop();
    cyc(2);
    chk(cpu_run, 1'b0);
    chk(osc_run, keep);
    pulse_wake();
    cyc(2 * TICKS - 6);
    chk(cpu_run, 1'b0);
    n = 0;
    while (cpu_run !== 1'b1 && n < 60) begin
      cyc(1);
      n++;
    end
    chk(cpu_run, 1'b1);
    $display("test stop_delay done");
  endtask

  task automatic t_fast_exit();
    apb(1'b1, `IDX_PLL_CONTROL, 32'h45);
    apb(1'b1, `IDX_STOP_CFG, 32'h00);
    pulse_stop();
    cyc(2);
    chk(cpu_run, 1'b0);
    pulse_wake();
    cyc(2);
    chk(cpu_run, 1'b1);
    apb(1'b1, `IDX_STOP_CFG, 32'h01);
    $display("test fast_exit done");
  endtask

  task automatic t_limp_stop();
    apb(1'b1, `IDX_PLL_CONTROL, 32'h44);
    pulse_stop();
    cyc(2);
    pulse_wake();
    cyc(2);
    chk(limp_active, 1'b1);
    chk(osc_run, 1'b1);
    chk(pll_drive.pll_power, 1'b1);
    vco_ticks(TICKS);
    cyc(3);
    chk(cpu_run, 1'b1);
    chk(limp_active, 1'b0);
    $display("test limp_stop done");
  endtask

  // reference loss, a mid-run reset and a missing pll supply
  task automatic t_ref_loss();
    apb(1'b1, `IDX_PLL_CONTROL, 32'h40);
    apb(1'b1, `IDX_PLL_FLAGS, 32'h02);
    ref_clk_good <= 1'b0;
    cyc(2);
    chk(limp_active, 1'b1);
    rchk(`IDX_PLL_FLAGS, 32'h03);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    pll_supply <= 1'b0;
    chk(limp_active, 1'b1);
    cyc(2);
    chk(limp_active, 1'b0);
    apb(1'b1, `IDX_PLL_CONTROL, 32'hE3);
    rchk(`IDX_PLL_CONTROL, 32'h21);
    apb(1'b1, `IDX_STOP_CFG, 32'h03);
    cyc(2);
    chk(cm_reset, 1'b1);
    apb(1'b1, `IDX_STOP_CFG, 32'h01);
    ref_clk_good <= 1'b1;
    pll_supply <= 1'b1;
    cyc(2);
    chk(cm_reset, 1'b0);
    $display("test ref_loss done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #100000;
    errors++;
    complete_run();
  end

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_map();
    t_limp_exit();
    t_tolerance();
    t_write_lock();
    t_monitor_reset();
    t_stop_delay(1'b0);
    t_stop_delay(1'b1);
    t_fast_exit();
    t_limp_stop();
    t_ref_loss();
    complete_run();
  end
endmodule
